// ### src/sfr_reg_access.sv
// Register-access command interpreter of a serial flash device.
`timescale 1ns/100ps
`include "sfr_consts.svh"
// Function
// - Config read streams config byte repeatedly.
// - Config read allowed even while busy.
// - Bank read streams bank byte repeatedly.
// - Bank write stores one byte into bank.
// - Bank bits supply high address when extended off.
// - Bank write needs no latch, flags untouched.
// - Legacy access then write loads bank bits 1:0.
// - Legacy sequence closes access, keeps extended bit.
// - Any other frame closes legacy access.
// - Register write needs write enable latch.
// - Eight bits status, sixteen both, else abort.
// - Self-timed write, busy flag, clears latch.
// - Failed register write sets error flag.
// - Protect bit clear ignores protect pin.
// - Protect bit plus low pin blocks writes.
// - Block protect bits select read-only region.
// - Quad mode disables protect pin.
// - Write enable sets latch on exact length, only while no self-timed write runs.
module sfr_reg_access
  import sfr_pkg::*;
#(
  parameter int BANK_BITS = 7,
  parameter int WRITE_CYCLES = `SFR_REG_WRITE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SCK,
  input wire logic CS_B,
  input wire logic SI,
  input wire logic WP_B,
  input wire logic REG_WRITE_FAIL,
  input wire logic [7:0] SECTOR_INDEX,
  output logic SO,
  output logic SO_OE,
  output logic [BANK_BITS-1:0] BANK_ADDR,
  output logic FOUR_BYTE_ADDR,
  output logic BUSY,
  output logic WRITE_ENABLED,
  output logic QUAD_MODE,
  output logic [2:0] BLOCK_PROTECT,
  output logic SECTOR_PROTECTED
);

  sfr_clk_state_type c;
  sfr_clk_state_type next_c;
  sfr_sck_state_type s;
  sfr_sck_state_type next_s;
  sfr_out_state_type o;
  sfr_out_state_type next_o;
  logic fresh;
  logic frame_rst;
  logic frame_end;
  logic [4:0] c0;
  logic [2:0] bp;
  logic [8:0] limit;
  logic hw_locked;
  logic wrr_len;
  logic [7:0] first_byte;

  // The frame marker and output register are held in reset while chip select is high.
  assign frame_rst = ~RST_B | CS_B;

  // Frame start marker; set asynchronously so no edge outside a frame is
  // needed to restart the bit counter.
  always_ff @(posedge SCK or posedge frame_rst) begin
    if (frame_rst) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Instruction and data shifting, most significant bit first.
  always_comb begin
    next_s = s;
    c0 = fresh ? 5'h00 : s.cnt;
    next_s.phase = fresh ? 3'h1 : 3'(s.phase + 3'h1);
    if (c0 < `SFR_BITS_OPCODE) begin
      next_s.op = {s.op[6:0], SI};
    end else begin
      next_s.data = {s.data[14:0], SI};
    end
    next_s.cnt = (c0 == `SFR_BITS_MAX) ? `SFR_BITS_MAX : 5'(c0 + 5'h01);
  end

  // The shifted frame stays put after chip select rises because the
  // serial clock stops, so the system clock can read it afterwards.
  always_ff @(posedge SCK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Read data goes out on falling edges; the register repeats each byte.
  always_comb begin
    next_o = o;
    next_o.so = 1'b0;
    next_o.so_oe = 1'b0;
    if (!fresh && s.cnt >= `SFR_BITS_OPCODE) begin
      if (s.op == `SFR_OP_CFG_READ) begin
        next_o.so = c.cr[~s.phase];
        next_o.so_oe = 1'b1;
      end else if (s.op == `SFR_OP_BANK_READ) begin
        next_o.so = c.bar[~s.phase];
        next_o.so_oe = 1'b1;
      end
    end
  end

  // The bank register changes only at frame ends; the config register also
  // changes when a self-timed write ends, which can fall inside a config read.
  always_ff @(negedge SCK or posedge frame_rst) begin
    if (frame_rst) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign SO = o.so;
  assign SO_OE = o.so_oe;

  // Frame end is the synchronised rise of chip select.
  assign frame_end = c.cs_s2 & ~c.cs_d;
  assign bp = c.sr[`SFR_SR_BP_LSB +: 3];
  assign limit = 9'h100 - (9'h100 >> (3'h7 - bp));
  assign hw_locked = c.sr[`SFR_SR_PROTECT] & ~c.wp_s2
                     & ~c.cr[`SFR_CR_QUAD];
  assign wrr_len = (s.cnt == `SFR_BITS_ONE_BYTE) |
                   (s.cnt == `SFR_BITS_TWO_BYTES);
  assign first_byte = (s.cnt == `SFR_BITS_TWO_BYTES) ? s.data[15:8]
                                                    : s.data[7:0];

  // Command execution and the self-timed write on the system clock.
  always_comb begin
    next_c = c;
    next_c.cs_s1 = CS_B;
    next_c.cs_s2 = c.cs_s1;
    next_c.cs_d = c.cs_s2;
    next_c.wp_s1 = WP_B;
    next_c.wp_s2 = c.wp_s1;
    // Protection of the sector being addressed by the array logic.
    if (bp == 3'h0) begin
      next_c.prot = 1'b0;
    end else if (bp == 3'h7) begin
      next_c.prot = 1'b1;
    end else begin
      next_c.prot = ({1'b0, SECTOR_INDEX} >= limit);
    end
    if (frame_end) begin
      // Every frame that is not the legacy access closes it.
      next_c.bar_open = 1'b0;
      if (s.op == `SFR_OP_LEGACY_BANK && s.cnt == `SFR_BITS_OPCODE) begin
        next_c.bar_open = 1'b1;
      end else if (s.op == `SFR_OP_WRITE_ENABLE) begin
        if (s.cnt == `SFR_BITS_OPCODE && c.wr == SFR_IDLE) begin
          next_c.sr[`SFR_SR_WEL] = 1'b1;
        end
      end else if (s.op == `SFR_OP_BANK_WRITE) begin
        if (s.cnt == `SFR_BITS_ONE_BYTE) begin
          next_c.bar = s.data[7:0] & `SFR_BAR_WRITABLE;
        end
      end else if (s.op == `SFR_OP_STAT_CFG_WRITE && wrr_len) begin
        if (c.bar_open) begin
          // Only the two low bank bits load; extended bit is kept.
          next_c.bar = (c.bar & ~`SFR_BAR_LEGACY_MASK) |
                       (first_byte & `SFR_BAR_LEGACY_MASK);
        end else if (c.sr[`SFR_SR_WEL] && c.wr == SFR_IDLE &&
                     !hw_locked) begin
          next_c.new_sr = first_byte;
          next_c.new_cr = s.data[7:0];
          next_c.new_cr_valid = (s.cnt == `SFR_BITS_TWO_BYTES);
          next_c.sr[`SFR_SR_BUSY] = 1'b1;
          next_c.timer = 16'(WRITE_CYCLES);
          next_c.wr = SFR_BUSY;
        end
      end
    end
    unique case (c.wr)
      SFR_IDLE: begin
        // The timer holds while no self-timed write runs.
      end
      SFR_BUSY: begin
        next_c.timer = 16'(c.timer - 16'h0001);
        if (c.timer == 16'h0001) begin
          if (REG_WRITE_FAIL) begin
            next_c.sr[`SFR_SR_PROG_ERR] = 1'b1;
          end else begin
            next_c.sr = (c.sr & ~`SFR_SR_WRITABLE) |
                        (c.new_sr & `SFR_SR_WRITABLE);
            if (c.new_cr_valid) begin
              next_c.cr = c.new_cr & `SFR_CR_WRITABLE;
            end
          end
          next_c.sr[`SFR_SR_BUSY] = 1'b0;
          next_c.sr[`SFR_SR_WEL] = 1'b0;
          next_c.wr = SFR_IDLE;
        end
      end
    endcase
  end

  // All system-clock state except the busy helper counter in one register.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      c <= '0;
      c.cs_s1 <= 1'b1;
      c.cs_s2 <= 1'b1;
      c.cs_d <= 1'b1;
      c.wr <= SFR_IDLE;
      c.sr <= `SFR_SR_RESET;
      c.cr <= `SFR_CR_RESET;
      c.bar <= `SFR_BAR_RESET;
    end else begin
      c <= next_c;
    end
  end

  // High address bits feed three-byte address commands when extended
  // addressing is off.
  assign BANK_ADDR = c.bar[BANK_BITS-1:0];
  assign FOUR_BYTE_ADDR = c.bar[`SFR_BAR_EXT];
  assign BUSY = c.sr[`SFR_SR_BUSY];
  assign WRITE_ENABLED = c.sr[`SFR_SR_WEL];
  assign QUAD_MODE = c.cr[`SFR_CR_QUAD];
  assign BLOCK_PROTECT = bp;
  assign SECTOR_PROTECTED = c.prot;

  // Helper: cycles spent busy, for the duration check.
  logic [15:0] busy_cnt;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt <= 16'h0000;
    end else if (c.sr[`SFR_SR_BUSY]) begin
      busy_cnt <= 16'(busy_cnt + 16'h0001);
    end else begin
      busy_cnt <= 16'h0000;
    end
  end

  sequence s_end(logic [7:0] op, logic [4:0] n);
    frame_end && s.op == op && s.cnt == n;
  endsequence

  sequence s_wrr_end;
    frame_end && s.op == `SFR_OP_STAT_CFG_WRITE && wrr_len;
  endsequence

  property p_write_enable_cmd_sets;
    @(posedge CLK) disable iff (!RST_B)
    s_end(`SFR_OP_WRITE_ENABLE, `SFR_BITS_OPCODE) and (c.wr == SFR_IDLE)
      |=> WRITE_ENABLED;
  endproperty
  a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)
    else $error("write enable did not set latch");

  property p_write_enable_cmd_len;
    @(posedge CLK) disable iff (!RST_B)
    frame_end && s.op == `SFR_OP_WRITE_ENABLE &&
      s.cnt != `SFR_BITS_OPCODE && !WRITE_ENABLED |=> !WRITE_ENABLED;
  endproperty
  a_write_enable_cmd_len: assert property (p_write_enable_cmd_len)
    else $error("write enable of wrong length set latch");

  property p_wrr_needs_wel;
    @(posedge CLK) disable iff (!RST_B)
    s_wrr_end and (!WRITE_ENABLED && !BUSY && !c.bar_open) |=> !BUSY;
  endproperty
  a_wrr_needs_wel: assert property (p_wrr_needs_wel)
    else $error("register write started without latch");

  property p_wrr_length;
    @(posedge CLK) disable iff (!RST_B)
    frame_end && s.op == `SFR_OP_STAT_CFG_WRITE && !wrr_len && !BUSY
      |=> !BUSY;
  endproperty
  a_wrr_length: assert property (p_wrr_length)
    else $error("register write of wrong length started");

  property p_sr_unprotected;
    @(posedge CLK) disable iff (!RST_B)
    s_wrr_end and (WRITE_ENABLED && !BUSY && !c.bar_open &&
      !c.sr[`SFR_SR_PROTECT]) |=> BUSY ##1 BUSY;
  endproperty
  a_sr_unprotected: assert property (p_sr_unprotected)
    else $error("unprotected register write not started");

  property p_hw_lock;
    @(posedge CLK) disable iff (!RST_B)
    s_wrr_end and (c.sr[`SFR_SR_PROTECT] && !c.wp_s2 && !QUAD_MODE &&
      !BUSY && !c.bar_open) |=> !BUSY;
  endproperty
  a_hw_lock: assert property (p_hw_lock)
    else $error("write accepted under pin protection");

  property p_write_time;
    @(posedge CLK) disable iff (!RST_B)
    $fell(BUSY) |-> busy_cnt == 16'(WRITE_CYCLES) && !WRITE_ENABLED;
  endproperty
  a_write_time: assert property (p_write_time)
    else $error("self-timed write length or latch wrong");

  // A failed write flags the error and leaves the protect bits alone.
  property p_write_fail;
    @(posedge CLK) disable iff (!RST_B)
    c.wr == SFR_BUSY && c.timer == 16'h0001 && REG_WRITE_FAIL |=>
      c.sr[`SFR_SR_PROG_ERR] && !BUSY && $stable(BLOCK_PROTECT);
  endproperty
  a_write_fail: assert property (p_write_fail)
    else $error("failed register write did not set error flag");

  property p_bank_write;
    @(posedge CLK) disable iff (!RST_B)
    s_end(`SFR_OP_BANK_WRITE, `SFR_BITS_ONE_BYTE) |=>
      c.bar == ($past(s.data[7:0]) & `SFR_BAR_WRITABLE) &&
      $stable(BUSY) && $stable(c.sr[`SFR_SR_PROG_ERR:`SFR_SR_ERASE_ERR]);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank write stored wrong value or touched flags");

  property p_legacy_write;
    @(posedge CLK) disable iff (!RST_B)
    s_wrr_end and c.bar_open |=> c.bar[1:0] == $past(first_byte[1:0]) &&
      $stable(c.bar[7:2]) && !c.bar_open && !BUSY;
  endproperty
  a_legacy_write: assert property (p_legacy_write)
    else $error("legacy bank load wrong");

  property p_legacy_close;
    @(posedge CLK) disable iff (!RST_B)
    frame_end && !(s.op == `SFR_OP_LEGACY_BANK &&
      s.cnt == `SFR_BITS_OPCODE) |=> !c.bar_open;
  endproperty
  a_legacy_close: assert property (p_legacy_close)
    else $error("legacy access left open");

  property p_block_all;
    @(posedge CLK) disable iff (!RST_B)
    bp == 3'h7 |=> SECTOR_PROTECTED;
  endproperty
  a_block_all: assert property (p_block_all)
    else $error("full block protect not applied");

  property p_block_none;
    @(posedge CLK) disable iff (!RST_B)
    bp == 3'h0 |=> !SECTOR_PROTECTED;
  endproperty
  a_block_none: assert property (p_block_none)
    else $error("sector protected with no protect bits");

endmodule : sfr_reg_access

// ### src/sfr_consts.svh
// Constants of the serial flash register-access command block.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// Instruction codes.
`define SFR_OP_CFG_READ 8'h35
`define SFR_OP_BANK_READ 8'h16
`define SFR_OP_BANK_WRITE 8'h17
`define SFR_OP_LEGACY_BANK 8'hb9
`define SFR_OP_STAT_CFG_WRITE 8'h01
`define SFR_OP_WRITE_ENABLE 8'h06

// Bit counts at chip select rise (instruction included).
`define SFR_BITS_OPCODE 5'h08
`define SFR_BITS_ONE_BYTE 5'h10
`define SFR_BITS_TWO_BYTES 5'h18
`define SFR_BITS_MAX 5'h1f

// Field positions in status register one, config and bank registers.
`define SFR_SR_BUSY 0
`define SFR_SR_WEL 1
`define SFR_SR_BP_LSB 2
`define SFR_SR_ERASE_ERR 5
`define SFR_SR_PROG_ERR 6
`define SFR_SR_PROTECT 7
`define SFR_CR_QUAD 1
`define SFR_BAR_EXT 7

// Reset values and writable masks.
`define SFR_SR_RESET 8'h00
`define SFR_CR_RESET 8'h00
`define SFR_BAR_RESET 8'h00
`define SFR_SR_WRITABLE 8'h9c
`define SFR_CR_WRITABLE 8'hff
`define SFR_BAR_WRITABLE 8'h83
`define SFR_BAR_LEGACY_MASK 8'h03

// Self-timed register write duration and clock rate.
`define SFR_REG_WRITE_NS 2000
`define SFR_CLK_MHZ 100
`define SFR_REG_WRITE_CYCLES ((`SFR_REG_WRITE_NS * `SFR_CLK_MHZ + 999) / 1000)

`endif

// ### src/sfr_pkg.sv
// Types of the serial flash register-access command block.
package sfr_pkg;

  // Self-timed write sequencer.
  typedef enum logic {SFR_IDLE, SFR_BUSY} sfr_wr_state_type;

  // State on the system clock.
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic wp_s1;
    logic wp_s2;
    sfr_wr_state_type wr;
    logic [15:0] timer;
    logic [7:0] sr;
    logic [7:0] cr;
    logic [7:0] bar;
    logic bar_open;
    logic [7:0] new_sr;
    logic [7:0] new_cr;
    logic new_cr_valid;
    logic prot;
  } sfr_clk_state_type;

  // State on the rising serial clock.
  typedef struct packed {
    logic [4:0] cnt;
    logic [2:0] phase;
    logic [7:0] op;
    logic [15:0] data;
  } sfr_sck_state_type;

  // State on the falling serial clock.
  typedef struct packed {
    logic so;
    logic so_oe;
  } sfr_out_state_type;

endpackage : sfr_pkg

// ### test/sfr_host_model.sv
// Host controller model that frames commands on the serial link.
`timescale 1ns/100ps
module sfr_host_model (
  output logic SCK,
  output logic CS_B,
  output logic SI,
  input wire logic SO
);
  // The link clock stands still low and chip select high between frames.
  initial begin
    SCK = 1'b0;
    CS_B = 1'b1;
    SI = 1'b0;
  end

  // One frame of nbits at a 12 ns clock; bits leave MSB first, change while
  // the clock is low and SO is taken at the same rise that samples SI.
  task automatic frame(input logic [31:0] tx, input int nbits,
                       output logic [31:0] rx);
    rx = 32'h00000000;
    #3.3;
    CS_B = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      SI = tx[i];
      #6;
      SCK = 1'b1;
      rx = {rx[30:0], SO};
      #6;
      SCK = 1'b0;
    end
    #6;
    CS_B = 1'b1;
    // A released line shows the inverse of its last bit, never a stale copy.
    SI = ~SI;
    // Chip select stays high long enough for the frame to be decoded.
    #60;
  endtask : frame
endmodule : sfr_host_model

// ### test/tb_spi_flash_register_access_cmds.sv
// Self-checking bench of the flash register-access command block.
`timescale 1ns/100ps
`define SFR_CHECK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s expected %h seen %h", n, e, g); \
  end end
module tb_spi_flash_register_access_cmds;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic wfail = 1'b0;
  logic [7:0] sect = 8'h00;
  logic sck, cs_b, si, so, so_oe, four, busy, write_enable_latch, quad, sprot;
  logic [6:0] bank;
  logic [2:0] bp;
  logic [31:0] rx;
  logic [31:0] seed = 32'hccc9fd34;
  logic [7:0] sr_e = 8'h00;
  logic [7:0] cr_e = 8'h00;
  logic [7:0] bar_e = 8'h00;
  logic [7:0] x;
  int error_cnt = 0;
  int compares = 0;
  int oe_cnt = 0;
  int k0 = 0;

  // System clock at 100 MHz.
  always #5 clk = ~clk;

  // Counts link rises at which the device drives its serial output.
  always @(posedge sck) begin
    if (so_oe === 1'b1) begin
      oe_cnt++;
    end
  end

  // A short self-timed write keeps the run brief.
  sfr_reg_access #(.WRITE_CYCLES(40)) i_sfr_reg_access (
    .CLK(clk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b), .SI(si),
    .WP_B(wp_b), .REG_WRITE_FAIL(wfail), .SECTOR_INDEX(sect), .SO(so),
    .SO_OE(so_oe), .BANK_ADDR(bank), .FOUR_BYTE_ADDR(four), .BUSY(busy),
    .WRITE_ENABLED(write_enable_latch), .QUAD_MODE(quad), .BLOCK_PROTECT(bp),
    .SECTOR_PROTECTED(sprot));
  sfr_host_model i_sfr_host_model (
    .SCK(sck), .CS_B(cs_b), .SI(si), .SO(so));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Protected sectors are the top 2**(b+1) of 256, none at 0, all at 7.
  function automatic logic prot_exp(input logic [2:0] b, input logic [7:0] s);
    if (b == 3'h0) return 1'b0;
    if (b == 3'h7) return 1'b1;
    return (int'(s) + (1 << (int'(b) + 1))) >= 256;
  endfunction : prot_exp

  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic xfer(input logic [31:0] tx, input int n);
    i_sfr_host_model.frame(tx, n, rx);
  endtask : xfer

  // Bounded wait for the self-timed write to end.
  task automatic wait_idle();
    int k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k >= 400) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_idle

  // Write enable, then a register write whose acceptance is predicted from
  // length, protect bit, protect pin and quad mode in the expected copies.
  task automatic wr_regs(input logic [15:0] d, input int nd);
    logic ok;
    xfer(32'h06, 8);
    `SFR_CHECK("latch", 1'b1, write_enable_latch)
    ok = (nd == 8 || nd == 16) && !(sr_e[7] && !wp_b && !cr_e[1]);
    xfer(32'({8'h01, d}) >> (16 - nd), 8 + nd);
    `SFR_CHECK("busy", ok, busy)
    if (ok) begin
      xfer(32'h3500, 16);
      `SFR_CHECK("config in write", cr_e, rx[7:0])
      `SFR_CHECK("busy held", 1'b1, busy)
    end
    wait_idle();
    if (ok && !wfail) begin
      sr_e = (sr_e & 8'h63) | (d[15:8] & 8'h9c);
      if (nd == 16) cr_e = d[7:0];
    end
    `SFR_CHECK("latch after", !ok, write_enable_latch)
    `SFR_CHECK("protect", sr_e[4:2], bp)
    `SFR_CHECK("quad", cr_e[1], quad)
  endtask : wr_regs

  // Main sequence: reset, then each command with its corner cases.
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    `SFR_CHECK("reset", 17'h0,
      {bank, four, busy, write_enable_latch, quad, bp, so, so_oe, sprot})
    xfer(32'h03, 7);
    xfer(32'h00c, 9);
    `SFR_CHECK("odd write enable", 1'b0, write_enable_latch)
    xfer(32'h01ff, 16);
    `SFR_CHECK("unlatched", 4'h0, {busy, bp})
    for (int i = 0; i < 4; i++) begin
      bar_e = (i == 3) ? 8'h83 : 8'(rnd()) & 8'h83;
      xfer(32'({8'h17, bar_e}), 16);
      `SFR_CHECK("bank", bar_e, {four, bank})
      `SFR_CHECK("flags", 2'b00, {busy, write_enable_latch})
      k0 = oe_cnt;
      xfer(32'({8'h16, 16'h0000}), 24);
      `SFR_CHECK("bank read", {bar_e, bar_e}, rx[15:0])
      `SFR_CHECK("bank drive", 16, oe_cnt - k0)
    end
    wr_regs({8'(rnd()) & 8'h1c, 8'(rnd()) & 8'hfd}, 16);
    k0 = oe_cnt;
    xfer(32'h350000, 24);
    `SFR_CHECK("config read", {cr_e, cr_e}, rx[15:0])
    `SFR_CHECK("config drive", 16, oe_cnt - k0)
    wr_regs(16'h1400, 12);
    for (int b = 0; b < 8; b++) begin
      wr_regs({3'b000, 3'(b), 10'h000}, 8);
      for (int j = 0; j < 6; j++) begin
        @(negedge clk);
        sect = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'(rnd());
        @(negedge clk);
        `SFR_CHECK("sector", prot_exp(3'(b), sect), sprot)
      end
    end
    wr_regs(16'h8400, 8);
    @(negedge clk);
    wp_b = 1'b0;
    wr_regs(16'h0800, 8);
    wr_regs(16'h0802, 16);
    @(negedge clk);
    wp_b = 1'b1;
    wr_regs(16'h8402, 16);
    @(negedge clk);
    wp_b = 1'b0;
    wr_regs(16'h8802, 16);
    wr_regs(16'h0800, 16);
    wr_regs(16'h1000, 8);
    // Legacy access then register write: only bank bits 1:0 move.
    x = 8'(rnd());
    xfer(32'hb9, 8);
    xfer(32'({8'h01, x, ~x}), 24);
    bar_e[1:0] = x[1:0];
    `SFR_CHECK("legacy bank", bar_e, {four, bank})
    `SFR_CHECK("legacy status", sr_e[4:2], bp)
    wait_idle();
    xfer(32'hb9, 8);
    wr_regs(16'h0c00, 8);
    `SFR_CHECK("bank kept", bar_e, {four, bank})
    // The failed write comes last: its error flag stays set, as no register write clears it.
    @(negedge clk);
    wfail = 1'b1;
    wr_regs(16'h1c00, 8);
    final_report();
  end
endmodule : tb_spi_flash_register_access_cmds
